// [src/mrq_decode_queue.sv]
// mrq_decode_queue: destination decode, address check and translation, four-entry
// command queue and memory cycle launch for a backplane memory controller.
// assumes rx is stable for the T3 tick and that the cycle logic pulses mem_done.
`timescale 1ns/1ps
module mrq_decode_queue import mrq_pkg::*; #(
	parameter logic [11:0] IO_BASE_HI = 12'h000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire mrq_rx_t rx,
	input wire logic mem_done,
	input wire mrq_axi_req_t axi_req,
	output mrq_axi_rsp_t axi_rsp,
	output logic [1:0] conf_code,
	output logic conf_valid,
	output logic cycle_go_pulse,
	output logic mem_busy,
	output logic [3:0] cyc_func,
	output logic [1:0] cyc_dest,
	output logic [27:0] addr_reg,
	output logic [31:0] file_data,
	output logic file_data_abort,
	output logic file_data_valid
);
	typedef struct packed {
		mrq_phase_t phase;
		mrq_cycle_t cyst;
		mrq_rx_t rx_lat;
		mrq_entry_t [QUEUE_DEPTH-1:0] slots;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [1:0] write_data_pending_count;
		logic refuse;
		logic [1:0] drain_left;
		logic [1:0] conf;
		logic conf_v;
		logic go;
		logic busy;
		logic [3:0] func;
		logic [1:0] dest;
		logic [27:0] areg;
		logic [31:0] fdata;
		logic fabort;
		logic fvalid;
		logic [11:0] cfg_ctrl;
		logic [12:0] cfg_start;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		mrq_axi_rsp_t rsp;
	} mrq_state_t;

	mrq_state_t s_q, s_d;

	// formats a function needs in the queue, command included
	function automatic logic [2:0] need_of(input logic [3:0] fn);
		case (fn)
			FN_WRITE, FN_ILK_WRITE: need_of = 3'd2;
			FN_EXT_WRITE: need_of = 3'd3;
			default: need_of = 3'd1;
		endcase
	endfunction : need_of

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		merge_bytes = r;
	endfunction : merge_bytes

	logic chip16k, interleave, odd_ctrl;
	logic [3:0] raw_array_size, bus_request_level;
	logic [6:0] size_chip, corrected_array_size;
	logic [13:0] upper_bound, rx_unit;
	logic [19:0] array_addr;
	logic ctrl_match, array_hit, io_hit, func_ok, fits;
	logic [1:0] dest_dec;
	logic [PTR_W-1:0] used;
	logic [2:0] free_space;
	logic q_empty, q_full, deq_cmd, enq_adv;
	mrq_entry_t head, new_entry;
	logic [31:0] status_word, rd_word;
	logic rd_hit;

	always_comb begin
		chip16k = s_q.cfg_ctrl[CHIP16K_BIT];
		interleave = s_q.cfg_ctrl[INTERLEAVE_BIT];
		odd_ctrl = s_q.cfg_ctrl[ODD_CTRL_BIT];
		raw_array_size = s_q.cfg_ctrl[RAW_SIZE_LSB +: 4];
		bus_request_level = s_q.cfg_ctrl[LEVEL_FLD_LSB +: 4];
		size_chip = chip16k ? {1'b0, raw_array_size, 2'b00} : {3'b000, raw_array_size};
		corrected_array_size = interleave ? {size_chip[5:0], 1'b0} : size_chip;
		upper_bound = {1'b0, s_q.cfg_start} + {7'h00, corrected_array_size};
		rx_unit = {1'b0, s_q.rx_lat.addr[26:14]};
		ctrl_match = !interleave || (s_q.rx_lat.addr[CTRL_SEL_BIT] == odd_ctrl);
		array_hit = (rx_unit >= {1'b0, s_q.cfg_start}) && (rx_unit < upper_bound) && ctrl_match;
		// translation by chip size and interleave
		case ({chip16k, interleave})
			2'b10: array_addr = s_q.rx_lat.addr[19:0];
			2'b11: array_addr = {s_q.rx_lat.addr[20:2], s_q.rx_lat.addr[0]};
			2'b00: array_addr = {4'h0, s_q.rx_lat.addr[17:16], s_q.rx_lat.addr[13:0]};
			default: array_addr = {4'h0, s_q.rx_lat.addr[18:16], s_q.rx_lat.addr[13:2],
				s_q.rx_lat.addr[0]};
		endcase
		io_hit = (s_q.rx_lat.addr[26:15] == IO_BASE_HI)
			&& (s_q.rx_lat.addr[LEVEL_LSB +: 4] == bus_request_level);
		if (s_q.rx_lat.addr[IO_SPACE_BIT]) begin
			dest_dec = !io_hit ? DEST_NONE : (s_q.rx_lat.addr[ROM_SEL_BIT] ? DEST_ROM : DEST_CFG);
		end else begin
			dest_dec = array_hit ? DEST_ARRAY : DEST_NONE;
		end
		case (s_q.rx_lat.func)
			FN_READ, FN_ILK_READ: func_ok = 1'b1;
			FN_EXT_READ, FN_EXT_WRITE: func_ok = (dest_dec == DEST_ARRAY);
			FN_WRITE, FN_ILK_WRITE: func_ok = (dest_dec == DEST_ARRAY)
				|| ((dest_dec == DEST_CFG) && (s_q.rx_lat.mask == 4'hf));
			default: func_ok = 1'b0;
		endcase
		used = s_q.wptr - s_q.rptr;
		free_space = 3'(QUEUE_DEPTH) - used;
		q_empty = (s_q.wptr == s_q.rptr);
		q_full = (used == PTR_W'(QUEUE_DEPTH));
		fits = (need_of(s_q.rx_lat.func) <= free_space) && !s_q.refuse;
		head = s_q.slots[s_q.rptr[1:0]];
		deq_cmd = (s_q.phase == PH_T1) && (s_q.cyst == CY_IDLE) && !q_empty;
		new_entry.is_cmd = (s_q.write_data_pending_count == 2'd0);
		new_entry.func = s_q.rx_lat.func;
		new_entry.dest = dest_dec;
		new_entry.abort = (s_q.rx_lat.tag != TAG_WDATA) || !s_q.rx_lat.parity_ok;
		if (s_q.write_data_pending_count != 2'd0) begin
			new_entry.word = s_q.rx_lat.data;
		end else if (s_q.rx_lat.addr[IO_SPACE_BIT]) begin
			new_entry.word = {4'h0, s_q.rx_lat.addr};
		end else begin
			new_entry.word = {12'h000, array_addr};
		end
		status_word = {9'h000, corrected_array_size, 2'b00, s_q.write_data_pending_count,
			s_q.refuse, s_q.busy, q_empty, q_full, 1'b0, s_q.rptr, 1'b0, s_q.wptr};
		rd_hit = 1'b1;
		case (axi_req.araddr)
			CTRL_OFS: rd_word = {20'h00000, s_q.cfg_ctrl};
			START_OFS: rd_word = {19'h00000, s_q.cfg_start};
			STATUS_OFS: rd_word = status_word;
			default: begin
				rd_word = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		enq_adv = 1'b0;
		s_d.go = 1'b0;
		s_d.conf_v = 1'b0;
		s_d.fvalid = 1'b0;
		case (s_q.phase)
			PH_T0: s_d.phase = PH_T1;
			PH_T1: s_d.phase = PH_T2;
			PH_T2: s_d.phase = PH_T3;
			PH_T3: s_d.phase = PH_T0;
			default: s_d.phase = PH_T0;
		endcase
		if (s_q.phase == PH_T3) begin
			s_d.rx_lat = rx;
		end
		if ((s_q.phase == PH_T1) && (s_q.rx_lat.tag != 2'h0)) begin
			// slot written, pointer only on success
			// a full queue's write slot is the head entry, so it is left alone
			if (!q_full) begin
				s_d.slots[s_q.wptr[1:0]] = new_entry;
			end
			s_d.conf_v = 1'b1;
			if (s_q.write_data_pending_count != 2'd0) begin
				enq_adv = 1'b1;
				s_d.conf = new_entry.abort ? CONF_ERROR : CONF_ACK;
				s_d.write_data_pending_count = (s_q.rx_lat.tag == TAG_WDATA)
					? s_q.write_data_pending_count - 2'd1 : 2'd0;
			end else if (s_q.rx_lat.tag != TAG_CMD) begin
				s_d.conf = CONF_NORESP;
			end else if (!s_q.rx_lat.parity_ok) begin
				s_d.conf = CONF_ERROR;
			end else if (dest_dec == DEST_NONE) begin
				s_d.conf = CONF_NORESP;
			end else if (!func_ok) begin
				s_d.conf = CONF_ERROR;
			end else if (!fits) begin
				s_d.conf = CONF_BUSY;
				s_d.refuse = 1'b1;
			end else begin
				enq_adv = 1'b1;
				s_d.conf = CONF_ACK;
				s_d.write_data_pending_count = 2'(need_of(s_q.rx_lat.func) - 3'd1);
			end
		end
		if (enq_adv) begin
			s_d.wptr = s_q.wptr + PTR_W'(1);
		end
		case (s_q.cyst)
			CY_IDLE: begin
				if (deq_cmd) begin
					// take the command, load address register
					s_d.rptr = s_q.rptr + PTR_W'(1);
					// a refusal raised at this same T1 survives the dequeue
					s_d.refuse = s_d.refuse && !s_q.refuse;
					s_d.func = head.func;
					s_d.dest = head.dest;
					s_d.areg = head.word[27:0];
					s_d.drain_left = 2'(need_of(head.func) - 3'd1);
					if (need_of(head.func) == 3'd1) begin
						s_d.go = 1'b1;
						s_d.busy = 1'b1;
						s_d.cyst = CY_BUSY;
					end else begin
						s_d.cyst = CY_DRAIN;
					end
				end
			end
			CY_DRAIN: begin
				if ((s_q.phase == PH_T1) && !q_empty) begin
					s_d.rptr = s_q.rptr + PTR_W'(1);
					s_d.refuse = s_d.refuse && !s_q.refuse;
					s_d.fdata = head.word;
					s_d.fabort = head.abort;
					s_d.fvalid = 1'b1;
					s_d.drain_left = s_q.drain_left - 2'd1;
					if (s_q.drain_left == 2'd1) begin
						s_d.go = 1'b1;
						s_d.busy = 1'b1;
						s_d.cyst = CY_BUSY;
					end
				end
			end
			CY_BUSY: begin
				if (mem_done) begin
					s_d.busy = 1'b0;
					s_d.cyst = CY_IDLE;
				end
			end
			default: s_d.cyst = CY_IDLE;
		endcase
		// AXI4-Lite write channel: address and data in either order
		if (axi_req.awvalid && s_q.rsp.awready) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_q.rsp.wready) begin
			s_d.w_got = 1'b1;
			s_d.w_data = axi_req.wdata;
			s_d.w_strb = axi_req.wstrb;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp = RESP_OKAY;
			case (s_q.aw_addr)
				CTRL_OFS: s_d.cfg_ctrl = 12'(merge_bytes({20'h00000, s_q.cfg_ctrl},
					s_q.w_data, s_q.w_strb));
				START_OFS: s_d.cfg_start = 13'(merge_bytes({19'h00000, s_q.cfg_start},
					s_q.w_data, s_q.w_strb));
				STATUS_OFS: s_d.rsp.bresp = RESP_OKAY;
				default: s_d.rsp.bresp = RESP_SLVERR;
			endcase
		end else if (s_q.rsp.bvalid && axi_req.bready) begin
			s_d.rsp.bvalid = 1'b0;
		end
		s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
		s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;
		if (axi_req.arvalid && s_q.rsp.arready) begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata = rd_word;
			s_d.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_q.rsp.rvalid && axi_req.rready) begin
			s_d.rsp.rvalid = 1'b0;
		end
		s_d.rsp.arready = !s_d.rsp.rvalid;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.phase <= PH_T0;
			s_q.cyst <= CY_IDLE;
			s_q.cfg_ctrl <= CTRL_RESET;
			s_q.cfg_start <= START_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_rsp = s_q.rsp;
	assign conf_code = s_q.conf;
	assign conf_valid = s_q.conf_v;
	assign cycle_go_pulse = s_q.go;
	assign mem_busy = s_q.busy;
	assign cyc_func = s_q.func;
	assign cyc_dest = s_q.dest;
	assign addr_reg = s_q.areg;
	assign file_data = s_q.fdata;
	assign file_data_abort = s_q.fabort;
	assign file_data_valid = s_q.fvalid;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence deq_of(int n);
		deq_cmd && (need_of(head.func) == 3'(n)) && (used >= PTR_W'(n));
	endsequence

	go_read_a: assert property (deq_of(1) |=> cycle_go_pulse && mem_busy)
		else $error("read did not launch go in the same bus cycle");
	go_write_a: assert property (deq_of(2) |=> !cycle_go_pulse [*4] ##1 cycle_go_pulse)
		else $error("single write go not one bus cycle late");
	go_ext_write_a: assert property (deq_of(3) |-> ##9 cycle_go_pulse)
		else $error("extended write go not two bus cycles late");
	busy_with_go_a: assert property (cycle_go_pulse |-> mem_busy)
		else $error("go without busy");
	busy_blocks_a: assert property (mem_busy && !mem_done |=> $stable(s_q.rptr))
		else $error("queue drained while busy");
	wptr_hold_a: assert property ((s_q.phase == PH_T1) && !enq_adv |=> $stable(s_q.wptr))
		else $error("write pointer moved for rejected format");
	queue_bound_a: assert property (used <= PTR_W'(QUEUE_DEPTH))
		else $error("queue overfilled");
	refuse_hold_a: assert property (s_q.refuse && !deq_cmd |=> $stable(s_q.wptr))
		else $error("entry accepted while refusing");
	deq_addr_a: assert property (deq_cmd |=> addr_reg == $past(head.word[27:0]))
		else $error("address register not loaded on dequeue");
endmodule : mrq_decode_queue

// [src/mrq_pkg.sv]
// mrq_pkg: constants, encodings and carrier types of the memory request decode queue.
// assumes a single 40 MHz clock and a backplane whose bus cycle spans four clk_sys ticks.
package mrq_pkg;
	localparam int CLK_MHZ = 40;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int QUEUE_DEPTH = 4;
	// queue pointers: two wrapping bits plus a lap bit that tells full from empty
	localparam int PTR_W = 3;
	// received address fields
	localparam int IO_SPACE_BIT = 27;
	localparam int CTRL_SEL_BIT = 1;
	localparam int LEVEL_LSB = 11;
	localparam int ROM_SEL_BIT = 10;
	// register byte addresses on the AXI4-Lite port
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] START_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	// control register fields
	localparam int CHIP16K_BIT = 0;
	localparam int INTERLEAVE_BIT = 1;
	localparam int ODD_CTRL_BIT = 2;
	localparam int RAW_SIZE_LSB = 4;
	localparam int LEVEL_FLD_LSB = 8;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [12:0] START_RESET = 13'h0000;
	// tag, function, destination and confirmation encodings
	localparam logic [1:0] TAG_CMD = 2'h1;
	localparam logic [1:0] TAG_WDATA = 2'h2;
	localparam logic [3:0] FN_READ = 4'h1;
	localparam logic [3:0] FN_EXT_READ = 4'h2;
	localparam logic [3:0] FN_WRITE = 4'h3;
	localparam logic [3:0] FN_EXT_WRITE = 4'h4;
	localparam logic [3:0] FN_ILK_READ = 4'h5;
	localparam logic [3:0] FN_ILK_WRITE = 4'h6;
	localparam logic [1:0] DEST_NONE = 2'h0;
	localparam logic [1:0] DEST_ARRAY = 2'h1;
	localparam logic [1:0] DEST_CFG = 2'h2;
	localparam logic [1:0] DEST_ROM = 2'h3;
	localparam logic [1:0] CONF_ACK = 2'h0;
	localparam logic [1:0] CONF_NORESP = 2'h1;
	localparam logic [1:0] CONF_BUSY = 2'h2;
	localparam logic [1:0] CONF_ERROR = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		PH_T0 = 4'b0001,
		PH_T1 = 4'b0010,
		PH_T2 = 4'b0100,
		PH_T3 = 4'b1000
	} mrq_phase_t;

	typedef enum logic [2:0] {
		CY_IDLE = 3'b001,
		CY_DRAIN = 3'b010,
		CY_BUSY = 3'b100
	} mrq_cycle_t;

	// one format as seen on the backplane information lines
	typedef struct packed {
		logic [1:0] tag;
		logic parity_ok;
		logic [3:0] func;
		logic [3:0] mask;
		logic [27:0] addr;
		logic [31:0] data;
	} mrq_rx_t;

	typedef struct packed {
		logic is_cmd;
		logic [3:0] func;
		logic [1:0] dest;
		logic abort;
		logic [31:0] word;
	} mrq_entry_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} mrq_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mrq_axi_rsp_t;
endpackage : mrq_pkg

// [testbench/mrq_nexus_model.sv]
// mrq_nexus_model: commanding nexus that puts one queued format on rx per bus cycle.
// assumes bus cycle phase restarts at T0 on the first clk_sys after reset release.
`timescale 1ns/1ps
module mrq_nexus_model import mrq_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	output mrq_rx_t rx
);
	logic [1:0] ph_q;
	mrq_rx_t pend[$];

	task push(input mrq_rx_t f);
		pend.push_back(f);
	endtask : push

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ph_q <= 2'h0;
			rx <= '0;
		end else begin
			ph_q <= ph_q + 2'h1;
			// formats in order, write data right after its command
			if (ph_q == 2'h2 && pend.size() != 0) begin
				rx <= pend.pop_front();
			end else if (ph_q == 2'h2) begin
				rx <= '0;
			end else begin
				rx <= ~rx;
			end
		end
	end
endmodule : mrq_nexus_model

// [testbench/memory_request_decode_queue_bench.sv]
// memory_request_decode_queue_bench: self-checking bench for the decode queue.
// assumes mrq_nexus_model drives rx and mem_done is answered by the bench.
`timescale 1ns/1ps
module memory_request_decode_queue_bench import mrq_pkg::*;;
	localparam logic [27:0] ARR = 28'h0007abc;
	localparam logic [27:0] CFG = 28'h8002804;
	localparam logic [27:0] ROM = 28'h8002c04;
	logic clk_sys, reset, mem_done, conf_valid, go, busy, fabort, fvalid, k16, il;
	mrq_rx_t rx, f;
	mrq_axi_req_t req;
	mrq_axi_rsp_t rsp;
	logic [1:0] conf_code, cdest;
	logic [3:0] cfunc;
	logic [27:0] areg, a;
	logic [31:0] fdata, rd, off;
	integer err_total, check_count, seed, i, k;
	logic [3:0] tf [7] = '{FN_READ, FN_EXT_READ, FN_WRITE, FN_EXT_WRITE, FN_ILK_READ, FN_READ,
		FN_ILK_WRITE};
	logic [27:0] ta [7] = '{ARR, ARR, ARR, ARR, CFG, ROM, CFG};
	logic [1:0] td [7] = '{DEST_ARRAY, DEST_ARRAY, DEST_ARRAY, DEST_ARRAY, DEST_CFG, DEST_ROM,
		DEST_CFG};
	integer tn [7] = '{0, 0, 1, 2, 0, 0, 1};

	mrq_decode_queue dut_u (.clk_sys(clk_sys), .reset(reset), .rx(rx), .mem_done(mem_done),
		.axi_req(req), .axi_rsp(rsp), .conf_code(conf_code), .conf_valid(conf_valid),
		.cycle_go_pulse(go), .mem_busy(busy), .cyc_func(cfunc), .cyc_dest(cdest),
		.addr_reg(areg), .file_data(fdata), .file_data_abort(fabort), .file_data_valid(fvalid));
	mrq_nexus_model nexus_u (.clk_sys(clk_sys), .reset(reset), .rx(rx));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task give_up;
		err_total = err_total + 1;
		report_and_stop;
	endtask : give_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function mrq_rx_t fm(input logic [1:0] t, input logic [3:0] fn, input logic [27:0] ad,
		input logic [31:0] d, input logic [3:0] m);
		fm = {t, 1'b1, fn, m, ad, d};
	endfunction : fm

	function logic [31:0] ctrl(input logic c16, input logic ci);
		ctrl = {20'h0, 4'h5, 4'hf, 2'h0, ci, c16};
	endfunction : ctrl

	// expected array address for chip size and interleave
	function logic [27:0] xl(input logic [27:0] ad, input logic c16, input logic ci);
		if (c16 && !ci) xl = {8'h0, ad[19:0]};
		else if (c16) xl = {8'h0, ad[20:2], ad[0]};
		else if (!ci) xl = {12'h0, ad[17:16], ad[13:0]};
		else xl = {12'h0, ad[18:16], ad[13:2], ad[0]};
	endfunction : xl

	task axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		integer n;
		@(posedge clk_sys);
		req.awaddr <= ad;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		req.bready <= 1'b0;
		if (n == 40) give_up;
		chk(32'(rsp.bresp), 32'(er));
	endtask : axi_wr

	task axi_rd(input logic [7:0] ad, input logic [1:0] er);
		integer n;
		@(posedge clk_sys);
		req.araddr <= ad;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		req.rready <= 1'b0;
		if (n == 40) give_up;
		rd = rsp.rdata;
		chk(32'(rsp.rresp), 32'(er));
	endtask : axi_rd

	task send(input mrq_rx_t fr, input logic [1:0] ec);
		integer n;
		nexus_u.push(fr);
		for (n = 0; n < 12; n++) begin
			@(posedge clk_sys);
			#1;
			if (conf_valid === 1'b1) break;
		end
		if (n == 12) give_up;
		chk(32'(conf_code), 32'(ec));
	endtask : send

	task pulse_done;
		@(posedge clk_sys);
		mem_done <= 1'b1;
		@(posedge clk_sys);
		mem_done <= 1'b0;
	endtask : pulse_done

	task wait_go;
		integer n;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys);
			#1;
			if (go === 1'b1) break;
		end
		if (n == 40) give_up;
		chk(32'(busy), 32'h1);
		chk(32'(cdest), 32'(DEST_ARRAY));
	endtask : wait_go

	// go lands four clocks after the last format's confirmation
	task expect_go(input logic [3:0] fn, input logic [1:0] ds, input logic [27:0] ad,
		input logic fin);
		repeat (4) @(posedge clk_sys);
		#1;
		chk(32'(go), 32'h1);
		chk(32'(busy), 32'h1);
		chk(32'(cfunc), 32'(fn));
		chk(32'(cdest), 32'(ds));
		chk(32'(areg), 32'(ad));
		if (fin) pulse_done;
	endtask : expect_go

	initial begin
		seed = 32'he347947e;
		err_total = 0;
		check_count = 0;
		reset = 1'b1;
		mem_done = 1'b0;
		req = '0;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		axi_rd(CTRL_OFS, RESP_OKAY);
		chk(rd, 32'h0);
		axi_rd(START_OFS, RESP_OKAY);
		chk(rd, 32'h0);
		axi_rd(8'h0c, RESP_SLVERR);
		chk(rd, 32'h0);
		axi_wr(8'h0c, 32'h1, RESP_SLVERR);
		axi_wr(START_OFS, 32'h1, RESP_OKAY);
		axi_wr(CTRL_OFS, ctrl(1'b1, 1'b0), RESP_OKAY);
		axi_rd(CTRL_OFS, RESP_OKAY);
		chk(rd, ctrl(1'b1, 1'b0));
		axi_wr(STATUS_OFS, 32'hffffffff, RESP_OKAY);
		axi_rd(STATUS_OFS, RESP_OKAY);
		chk(32'(rd[10:8]), 32'h2);
		$display("registers done");
		for (i = 0; i < 7; i++) begin
			send(fm(TAG_CMD, tf[i], ta[i], 32'h0, 4'hf), CONF_ACK);
			for (k = 0; k < tn[i]; k++) begin
				send(fm(TAG_WDATA, 4'h0, 28'h0, 32'h5a00 + k, 4'hf), CONF_ACK);
			end
			expect_go(tf[i], td[i], ta[i][27] ? ta[i] : xl(ta[i], 1'b1, 1'b0), 1'b1);
			if (tn[i] > 0) chk(fdata, 32'h5a00 + tn[i] - 1);
		end
		send(fm(TAG_CMD, FN_WRITE, ARR, 32'h0, 4'hf), CONF_ACK);
		send(fm(TAG_CMD, FN_READ, ARR, 32'h0, 4'hf), CONF_ERROR);
		expect_go(FN_WRITE, DEST_ARRAY, xl(ARR, 1'b1, 1'b0), 1'b1);
		chk(32'(fabort), 32'h1);
		$display("commands done");
		axi_wr(START_OFS, 32'h1, RESP_OKAY);
		axi_wr(CTRL_OFS, ctrl(1'b1, 1'b0), RESP_OKAY);
		send(fm(TAG_WDATA, 4'h0, 28'h0, 32'h1, 4'hf), CONF_NORESP);
		f = fm(TAG_CMD, FN_READ, ARR, 32'h0, 4'hf);
		f.parity_ok = 1'b0;
		send(f, CONF_ERROR);
		send(fm(TAG_CMD, 4'h7, ARR, 32'h0, 4'hf), CONF_ERROR);
		send(fm(TAG_CMD, FN_READ, 28'h0000100, 32'h0, 4'hf), CONF_NORESP);
		send(fm(TAG_CMD, FN_READ, 28'h00f4000, 32'h0, 4'hf), CONF_NORESP);
		send(fm(TAG_CMD, FN_READ, CFG ^ 28'h800, 32'h0, 4'hf), CONF_NORESP);
		send(fm(TAG_CMD, FN_READ, CFG | 28'h8000, 32'h0, 4'hf), CONF_NORESP);
		send(fm(TAG_CMD, FN_EXT_READ, CFG, 32'h0, 4'hf), CONF_ERROR);
		send(fm(TAG_CMD, FN_WRITE, CFG, 32'h0, 4'h7), CONF_ERROR);
		send(fm(TAG_CMD, FN_WRITE, ROM, 32'h0, 4'hf), CONF_ERROR);
		axi_rd(STATUS_OFS, RESP_OKAY);
		chk(32'(rd[10:8]), 32'h2);
		chk(32'(rd[2:0]), 32'(rd[6:4]));
		$display("refusals done");
		for (i = 0; i < 8; i++) begin
			off = $random(seed);
			k16 = off[20];
			il = off[21];
			a = {1'b0, 13'h1, off[13:2], off[1] & ~il, off[0]};
			axi_wr(CTRL_OFS, ctrl(k16, il), RESP_OKAY);
			send(fm(TAG_CMD, FN_READ, a, 32'h0, 4'hf), CONF_ACK);
			expect_go(FN_READ, DEST_ARRAY, xl(a, k16, il), 1'b1);
		end
		axi_wr(CTRL_OFS, ctrl(1'b1, 1'b1), RESP_OKAY);
		send(fm(TAG_CMD, FN_READ, ARR | 28'h2, 32'h0, 4'hf), CONF_NORESP);
		axi_wr(CTRL_OFS, ctrl(1'b1, 1'b0), RESP_OKAY);
		$display("translation done");
		send(fm(TAG_CMD, FN_READ, ARR, 32'h0, 4'hf), CONF_ACK);
		expect_go(FN_READ, DEST_ARRAY, xl(ARR, 1'b1, 1'b0), 1'b0);
		send(fm(TAG_CMD, FN_EXT_WRITE, ARR, 32'h0, 4'hf), CONF_ACK);
		for (i = 0; i < 2; i++) begin
			send(fm(TAG_WDATA, 4'h0, 28'h0, 32'h77 + i, 4'hf), CONF_ACK);
		end
		send(fm(TAG_CMD, FN_EXT_WRITE, ARR, 32'h0, 4'hf), CONF_BUSY);
		send(fm(TAG_CMD, FN_READ, ARR, 32'h0, 4'hf), CONF_BUSY);
		chk(32'(go), 32'h0);
		pulse_done;
		wait_go;
		chk(fdata, 32'h78);
		send(fm(TAG_CMD, FN_WRITE, ARR, 32'h0, 4'hf), CONF_ACK);
		send(fm(TAG_WDATA, 4'h0, 28'h0, 32'h99, 4'hf), CONF_ACK);
		for (i = 0; i < 2; i++) begin
			send(fm(TAG_CMD, FN_READ, ARR, 32'h0, 4'hf), CONF_ACK);
		end
		send(fm(TAG_CMD, FN_READ, ROM, 32'h0, 4'hf), CONF_BUSY);
		axi_rd(STATUS_OFS, RESP_OKAY);
		chk(32'(rd[9:8]), 32'h1);
		for (i = 0; i < 3; i++) begin
			pulse_done;
			wait_go;
		end
		pulse_done;
		repeat (8) @(posedge clk_sys);
		axi_rd(STATUS_OFS, RESP_OKAY);
		chk(32'(rd[10:8]), 32'h2);
		$display("queue done");
		report_and_stop;
	end
endmodule : memory_request_decode_queue_bench
